// *** rtl/fml_pkg.sv ***
package fml_pkg;
  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CON_BAUD = 115200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / CON_BAUD;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] OFS_ACTIVE = 5'h00;
  localparam logic [4:0] OFS_HISTORY = 5'h04;
  localparam logic [4:0] OFS_CONFIG = 5'h08;
  localparam logic [4:0] OFS_COMMAND = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFS_PERMIT = 5'h18;
  ////////////////////////////////////////////////////////////////////////////
  // fault bit positions
  localparam int NUM_FAULTS = 9;
  localparam int BIT_LOCK = 0;
  localparam int BIT_LOOP = 1;
  localparam int BIT_PEDAL_RANGE = 2;
  localparam int BIT_PEDAL_CAL = 3;
  localparam int BIT_DRIVE_LINK = 4;
  localparam int BIT_CHARGE_INLET = 5;
  localparam int BIT_NEG_RELAY = 6;
  localparam int BIT_POS_RELAY = 7;
  localparam int BIT_PRECHARGE = 8;
  localparam logic [8:0] BLOCK_CONTACTOR = 9'h1C3;
  localparam logic [8:0] BLOCK_NETWORK = 9'h0C3;
  localparam logic [8:0] BLOCK_MOTOR = 9'h03C;
  ////////////////////////////////////////////////////////////////////////////
  // config and command fields, reset values
  localparam int CFG_CONFIGURED = 0;
  localparam int CFG_LOOP_EN = 1;
  localparam int CFG_VOLT_PRE = 2;
  localparam int CFG_CURR_PRE = 3;
  localparam int CFG_CHG_PORT = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam int CMD_UNLOCK = 0;
  localparam int CMD_HIST_ARM = 1;
  localparam int CMD_RESTART = 2;
  localparam logic [8:0] FAULT_RESET = 9'h000;
  ////////////////////////////////////////////////////////////////////////////
  // console characters
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_MENU = 8'h73;
  localparam logic [7:0] CH_QUIT = 8'h71;
  localparam logic [7:0] CH_UNLOCK = 8'h55;
  localparam logic [7:0] CH_HIST = 8'h50;
  localparam logic [7:0] CH_BOOT = 8'h5A;
  localparam logic [7:0] CH_BOOT_SAVE = 8'h58;

  typedef enum logic [1:0] {
    FML_CON_CHAR = 2'b00,
    FML_CON_LF = 2'b01,
    FML_CON_CR = 2'b10
  } fml_con_t;
endpackage

// *** rtl/fml_sync.sv ***
`timescale 1ns/100ps
module fml_sync #(
  parameter int WIDTH = 12
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("fml_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// *** rtl/fml_uart_rx.sv ***
`timescale 1ns/100ps
module fml_uart_rx #(
  parameter int BIT_CYCLES = 173
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // line, already synchronised
  input wire logic rxd,
  // received byte
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);
  logic busy;
  logic [CW-1:0] cnt;
  logic [3:0] nbit;
  logic [7:0] shift;
  wire tick = (cnt == '0);
  wire last = (nbit == 4'h9);

  initial begin
    if (BIT_CYCLES < 4) $error("fml_uart_rx: BIT_CYCLES too small");
  end

  // sample in mid bit; a low start that vanishes by mid bit is a glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= '0;
      nbit <= 4'h0;
      shift <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (!busy) begin
        if (!rxd) begin
          busy <= 1'b1;
          cnt <= HALF;
          nbit <= 4'h0;
        end
      end else if (!tick) begin
        cnt <= cnt - 1'b1;
      end else begin
        cnt <= FULL;
        nbit <= nbit + 4'h1;
        if (nbit == 4'h0 && rxd) busy <= 1'b0;
        else if (last) begin
          busy <= 1'b0;
          rx_byte <= shift;
          rx_valid <= rxd;
        end else shift <= {rxd, shift[7:1]};
      end
    end
  end
endmodule

// *** rtl/fml_core.sv ***
`timescale 1ns/100ps
module fml_core #(
  parameter int BIT_CYCLES = fml_pkg::BIT_CYCLES
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // service console
  input wire logic con_rxd,
  // fault detector pins
  input wire logic hw_failure,
  input wire logic loop_12v_present,
  input wire logic pedal_out_of_range,
  input wire logic pedal_cal_busy,
  input wire logic pedal_cal_invalid,
  input wire logic drive_msg_bad,
  input wire logic inlet_out_of_bounds,
  input wire logic neg_relay_leaking,
  input wire logic pos_relay_leaking,
  input wire logic pre_end_current_miss,
  input wire logic pre_end_voltage_miss,
  // permits
  output logic contactor_close_ok,
  output logic net_ctrl_ok,
  output logic motor_ctrl_ok
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [11:0] pins;
  fml_sync #(.WIDTH(12)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({con_rxd, pre_end_voltage_miss, pre_end_current_miss, pos_relay_leaking,
               neg_relay_leaking, inlet_out_of_bounds, drive_msg_bad, pedal_cal_invalid,
               pedal_cal_busy, pedal_out_of_range, loop_12v_present, hw_failure}),
    .sync_out(pins)
  );
  wire det_hw_fail = pins[0];
  wire det_loop_ok = pins[1];
  wire det_pedal_oor = pins[2];
  wire det_cal = pins[3] | pins[4];
  wire det_drive_bad = pins[5];
  wire det_inlet_bad = pins[6];
  wire det_neg_leak = pins[7];
  wire det_pos_leak = pins[8];
  wire det_pre_miss = pins[9] | pins[10];
  wire rxd_s = pins[11];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [8:0] active;
  logic [8:0] history;
  logic [4:0] cfg;
  logic [8:0] irq_status;
  logic [8:0] irq_mask;
  logic hist_armed;

  // bus decode: a request is served in the cycle waitrequest is still high
  wire bus_go = (avs_read | avs_write) & avs_waitrequest;
  wire wr_go = bus_go & avs_write;
  wire wr_cfg = wr_go && avs_address == fml_pkg::OFS_CONFIG;
  wire wr_cmd = wr_go && avs_address == fml_pkg::OFS_COMMAND && avs_byteenable[0];
  wire wr_ists = wr_go && avs_address == fml_pkg::OFS_IRQ_STATUS;
  wire wr_imsk = wr_go && avs_address == fml_pkg::OFS_IRQ_MASK;
  wire [31:0] wmask = be_merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable);
  wire [31:0] wdat = avs_writedata & wmask;
  wire [31:0] cfg_new = be_merge({27'h0, cfg}, avs_writedata, avs_byteenable);
  wire [31:0] msk_new = be_merge({23'h0, irq_mask}, avs_writedata, avs_byteenable);

  wire cfg_configured = cfg[fml_pkg::CFG_CONFIGURED];
  wire cfg_loop_en = cfg[fml_pkg::CFG_LOOP_EN];
  wire cfg_volt_pre = cfg[fml_pkg::CFG_VOLT_PRE];
  wire cfg_curr_pre = cfg[fml_pkg::CFG_CURR_PRE];
  wire cfg_chg_port = cfg[fml_pkg::CFG_CHG_PORT];

  ////////////////////////////////////////////////////////////////////////////
  // console receiver and line parser
  logic [7:0] rx_byte;
  logic rx_valid;
  fml_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rxd(rxd_s),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  fml_pkg::fml_con_t con_state;
  fml_pkg::fml_con_t next_con_state;
  logic [7:0] con_char;
  logic in_menu;

  // a letter counts only once newline and then carriage return follow it
  wire con_exec = rx_valid && con_state == fml_pkg::FML_CON_CR &&
                  rx_byte == fml_pkg::CH_CR;
  wire con_menu = con_exec && con_char == fml_pkg::CH_MENU;
  wire con_quit = con_exec && con_char == fml_pkg::CH_QUIT;
  wire con_unlock = con_exec && in_menu && con_char == fml_pkg::CH_UNLOCK;
  wire con_arm = con_exec && in_menu && con_char == fml_pkg::CH_HIST;
  wire con_boot = con_exec && in_menu &&
                  (con_char == fml_pkg::CH_BOOT || con_char == fml_pkg::CH_BOOT_SAVE);

  always_comb begin
    next_con_state = con_state;
    if (rx_valid) begin
      case (con_state)
        fml_pkg::FML_CON_CHAR: begin
          if (rx_byte != fml_pkg::CH_LF && rx_byte != fml_pkg::CH_CR) begin
            next_con_state = fml_pkg::FML_CON_LF;
          end
        end
        fml_pkg::FML_CON_LF: begin
          next_con_state = (rx_byte == fml_pkg::CH_LF) ? fml_pkg::FML_CON_CR
                                                       : fml_pkg::FML_CON_CHAR;
        end
        default: next_con_state = fml_pkg::FML_CON_CHAR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      con_state <= fml_pkg::FML_CON_CHAR;
      con_char <= 8'h00;
      in_menu <= 1'b0;
    end else if (ce) begin
      con_state <= next_con_state;
      if (rx_valid && con_state == fml_pkg::FML_CON_CHAR) con_char <= rx_byte;
      if (con_menu) in_menu <= 1'b1;
      else if (con_quit) in_menu <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commands from console or register
  wire do_unlock = con_unlock | (wr_cmd & avs_writedata[fml_pkg::CMD_UNLOCK]);
  wire do_arm = con_arm | (wr_cmd & avs_writedata[fml_pkg::CMD_HIST_ARM]);
  wire do_boot = con_boot | (wr_cmd & avs_writedata[fml_pkg::CMD_RESTART]);
  // the history reset lands on the next restart, or on a restart given in the same cycle as the arm
  wire hist_clear = do_boot & (hist_armed | do_arm);

  ////////////////////////////////////////////////////////////////////////////
  // fault matrix
  logic [8:0] next_active;
  always_comb begin
    next_active = fml_pkg::FAULT_RESET;
    // a persisting cause beats the unlock in the same cycle
    next_active[fml_pkg::BIT_LOCK] = !cfg_configured || det_hw_fail ||
                                     (active[fml_pkg::BIT_LOCK] && !do_unlock);
    next_active[fml_pkg::BIT_LOOP] = active[fml_pkg::BIT_LOOP] ||
                                     (cfg_loop_en && !det_loop_ok);
    next_active[fml_pkg::BIT_PEDAL_RANGE] = det_pedal_oor;
    next_active[fml_pkg::BIT_PEDAL_CAL] = det_cal;
    next_active[fml_pkg::BIT_DRIVE_LINK] = det_drive_bad;
    next_active[fml_pkg::BIT_CHARGE_INLET] = cfg_chg_port && det_inlet_bad;
    next_active[fml_pkg::BIT_NEG_RELAY] = active[fml_pkg::BIT_NEG_RELAY] ||
                                          (cfg_volt_pre && det_neg_leak);
    next_active[fml_pkg::BIT_POS_RELAY] = active[fml_pkg::BIT_POS_RELAY] ||
                                          (cfg_volt_pre && det_pos_leak);
    next_active[fml_pkg::BIT_PRECHARGE] = active[fml_pkg::BIT_PRECHARGE] ||
                                          (cfg_volt_pre && cfg_curr_pre && det_pre_miss);
  end

  wire [8:0] next_history = (hist_clear ? fml_pkg::FAULT_RESET : history) |
                            active;
  wire [8:0] fault_rise = next_active & ~active;
  wire [8:0] w1c = wr_ists ? wdat[8:0] : 9'h000;

  always_ff @(posedge clk) begin
    if (rst) begin
      active <= fml_pkg::FAULT_RESET;
      history <= fml_pkg::FAULT_RESET;
      hist_armed <= 1'b0;
    end else if (ce) begin
      active <= next_active;
      history <= next_history;
      hist_armed <= (hist_armed | do_arm) & ~do_boot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // permits and interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      contactor_close_ok <= 1'b0;
      net_ctrl_ok <= 1'b0;
      motor_ctrl_ok <= 1'b0;
      irq_status <= fml_pkg::FAULT_RESET;
      irq_mask <= fml_pkg::FAULT_RESET;
      irq <= 1'b0;
      cfg <= fml_pkg::CFG_RESET;
    end else if (ce) begin
      contactor_close_ok <= ~|(next_active & fml_pkg::BLOCK_CONTACTOR);
      net_ctrl_ok <= ~|(next_active & fml_pkg::BLOCK_NETWORK);
      motor_ctrl_ok <= ~|(next_active & fml_pkg::BLOCK_MOTOR);
      // a new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~w1c) | fault_rise;
      if (wr_imsk) irq_mask <= msk_new[8:0];
      irq <= |(((irq_status & ~w1c) | fault_rise) & (wr_imsk ? msk_new[8:0] : irq_mask));
      if (wr_cfg) cfg <= cfg_new[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, then waitrequest low for one cycle
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      fml_pkg::OFS_ACTIVE: rd_mux = {23'h0, active};
      fml_pkg::OFS_HISTORY: rd_mux = {23'h0, history};
      fml_pkg::OFS_CONFIG: rd_mux = {27'h0, cfg};
      fml_pkg::OFS_COMMAND: rd_mux = {31'h0, hist_armed};
      fml_pkg::OFS_IRQ_STATUS: rd_mux = {23'h0, irq_status};
      fml_pkg::OFS_IRQ_MASK: rd_mux = {23'h0, irq_mask};
      fml_pkg::OFS_PERMIT: rd_mux = {29'h0, motor_ctrl_ok, net_ctrl_ok, contactor_close_ok};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      avs_waitrequest <= ~bus_go;
      if (bus_go && avs_read) avs_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  lock_holds_a: assert property (@(posedge clk) disable iff (rst)
    ce && active[fml_pkg::BIT_LOCK] && !do_unlock |=> active[fml_pkg::BIT_LOCK])
    else $error("lock fault dropped without a command");
  lock_cause_a: assert property (@(posedge clk) disable iff (rst)
    ce && (!cfg_configured || det_hw_fail) |=> active[fml_pkg::BIT_LOCK] && !contactor_close_ok)
    else $error("lock fault not raised for its cause");
  loop_sets_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_loop_en && !det_loop_ok ##1 ce [*2] |-> active[fml_pkg::BIT_LOOP] && !net_ctrl_ok)
    else $error("safety loop fault missing");
  loop_sticky_a: assert property (@(posedge clk) disable iff (rst)
    active[fml_pkg::BIT_LOOP] |=> active[fml_pkg::BIT_LOOP])
    else $error("safety loop fault cleared without reset");
  pedal_follow_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> active[fml_pkg::BIT_PEDAL_RANGE] == $past(det_pedal_oor))
    else $error("pedal range fault does not follow detector");
  motor_block_a: assert property (@(posedge clk) disable iff (rst)
    ce && det_cal |=> !motor_ctrl_ok && active[fml_pkg::BIT_PEDAL_CAL])
    else $error("motor not blocked during calibration");
  relay_sticky_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_volt_pre && det_pos_leak |=> (active[fml_pkg::BIT_POS_RELAY] [*3]))
    else $error("relay fault not held");
  // without a bus charge port the inlet detector is meaningless and must stay masked
  inlet_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && !cfg_chg_port |=> !active[fml_pkg::BIT_CHARGE_INLET])
    else $error("charge inlet fault without a charge port");
  history_keep_a: assert property (@(posedge clk) disable iff (rst)
    ce && !hist_clear |=> (history & $past(active)) == $past(active)
                          && (history & $past(history)) == $past(history))
    else $error("history lost a fault");
  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    ce && bus_go ##1 ce |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle wide");
endmodule

// *** verification/fml_console_model.sv ***
`timescale 1ns/100ps
// service console model: 8N1 frames, lsb first, line idles high
module fml_console_model #(
  parameter int BIT_CYCLES = 8
) (
  // clocking
  input wire logic clk,
  // serial line into the block
  output logic rxd
);
  initial begin
    rxd = 1'b1;
  end

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= fr[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask

  // idle time after the line lets the command land before anyone looks
  task automatic send_line(input logic [7:0] b);
    send_byte(b);
    send_byte(fml_pkg::CH_LF);
    send_byte(fml_pkg::CH_CR);
    repeat (2 * BIT_CYCLES) @(posedge clk);
  endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
  // short bit time keeps console frames cheap
  localparam int BC = 8;
  logic clk, rst, ce, rd, wr, wreq, irq, rxd;
  logic [4:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] be, mot, leak;
  logic hw, loop_ok, cal_bad, c_ok, n_ok, m_ok;
  int n_mismatch, compares;

  fml_core #(.BIT_CYCLES(BC)) u_fml_core (
    .clk(clk), .rst(rst), .ce(ce),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq),
    .con_rxd(rxd), .hw_failure(hw), .loop_12v_present(loop_ok),
    .pedal_out_of_range(mot[0]), .pedal_cal_busy(mot[1]), .pedal_cal_invalid(cal_bad),
    .drive_msg_bad(mot[2]), .inlet_out_of_bounds(mot[3]),
    .neg_relay_leaking(leak[0]), .pos_relay_leaking(leak[1]),
    .pre_end_current_miss(leak[2]), .pre_end_voltage_miss(leak[3]),
    .contactor_close_ok(c_ok), .net_ctrl_ok(n_ok), .motor_ctrl_ok(m_ok)
  );

  fml_console_model #(.BIT_CYCLES(BC)) u_fml_console_model (.clk(clk), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one avalon cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic rreg(input logic [4:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, ex, q);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // detector pins reach the active word in 3 edges, history one later
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic perm(input logic [2:0] ex);
    chk("permits", {29'h0, ex}, {29'h0, m_ok, n_ok, c_ok});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h1, "active");
    rreg(fml_pkg::OFS_HISTORY, 32'h1, "history");
    perm(3'h4);
    rreg(fml_pkg::OFS_CONFIG, 32'h0, "config");
    rreg(5'h1C, 32'h0, "unmapped");
    rreg(fml_pkg::OFS_PERMIT, 32'h4, "permit reg");
  endtask

  task automatic t_lock();
    wreg(fml_pkg::OFS_CONFIG, 32'h1F);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h1, "lock kept");
    wreg(fml_pkg::OFS_COMMAND, 32'h1);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h0, "unlocked");
    perm(3'h7);
    hw <= 1'b1;
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h1, "hw lock");
    perm(3'h4);
    wreg(fml_pkg::OFS_COMMAND, 32'h1);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h1, "hw lock held");
    hw <= 1'b0;
    settle();
    wreg(fml_pkg::OFS_COMMAND, 32'h1);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h0, "lock cleared");
  endtask

  task automatic t_self();
    for (int i = 0; i < 4; i++) begin
      mot <= 4'(1 << i);
      settle();
      rreg(fml_pkg::OFS_ACTIVE, 32'h4 << i, "motor set");
      perm(3'h3);
      mot <= 4'h0;
      settle();
      rreg(fml_pkg::OFS_ACTIVE, 32'h0, "motor clear");
      perm(3'h7);
    end
    cal_bad <= 1'b1;
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h8, "cal invalid");
    cal_bad <= 1'b0;
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h0, "cal done");
    rreg(fml_pkg::OFS_HISTORY, 32'h3D, "history kept");
  endtask

  task automatic t_sticky();
    logic [31:0] ex [4] = '{32'h42, 32'hC2, 32'h1C2, 32'h1C2};
    loop_ok <= 1'b0;
    settle();
    loop_ok <= 1'b1;
    settle();
    wreg(fml_pkg::OFS_COMMAND, 32'h1);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h2, "loop sticky");
    perm(3'h4);
    for (int i = 0; i < 4; i++) begin
      leak <= 4'(1 << i);
      settle();
      leak <= 4'h0;
      settle();
      rreg(fml_pkg::OFS_ACTIVE, ex[i], "relay sticky");
    end
    perm(3'h4);
    rreg(fml_pkg::OFS_HISTORY, 32'h1FF, "history all");
  endtask

  task automatic t_irq();
    wreg(fml_pkg::OFS_IRQ_STATUS, 32'h1FF);
    rreg(fml_pkg::OFS_IRQ_STATUS, 32'h0, "status clear");
    wreg(fml_pkg::OFS_IRQ_MASK, 32'h4);
    mot <= 4'h1;
    settle();
    chk("irq up", 32'h1, {31'h0, irq});
    rreg(fml_pkg::OFS_IRQ_STATUS, 32'h4, "status set");
    // masked event must not hold the line once bit 2 is cleared
    mot <= 4'h2;
    settle();
    wreg(fml_pkg::OFS_IRQ_STATUS, 32'h4);
    settle();
    chk("irq down", 32'h0, {31'h0, irq});
    rreg(fml_pkg::OFS_IRQ_STATUS, 32'h8, "status masked");
    mot <= 4'h0;
    wreg(fml_pkg::OFS_IRQ_STATUS, 32'h8);
    rreg(fml_pkg::OFS_IRQ_MASK, 32'h4, "mask");
  endtask

  task automatic t_console();
    u_fml_console_model.send_line(fml_pkg::CH_HIST);
    rreg(fml_pkg::OFS_COMMAND, 32'h0, "arm outside menu");
    u_fml_console_model.send_line(fml_pkg::CH_MENU);
    u_fml_console_model.send_line(fml_pkg::CH_HIST);
    rreg(fml_pkg::OFS_COMMAND, 32'h1, "armed");
    rreg(fml_pkg::OFS_HISTORY, 32'h1FF, "before restart");
    u_fml_console_model.send_line(fml_pkg::CH_BOOT_SAVE);
    rreg(fml_pkg::OFS_HISTORY, 32'h1C2, "after restart");
    u_fml_console_model.send_line(fml_pkg::CH_QUIT);
    mot <= 4'h1;
    settle();
    mot <= 4'h0;
    settle();
    wreg(fml_pkg::OFS_COMMAND, 32'h4);
    settle();
    rreg(fml_pkg::OFS_HISTORY, 32'h1C6, "unarmed restart");
    wreg(fml_pkg::OFS_COMMAND, 32'h2);
    wreg(fml_pkg::OFS_COMMAND, 32'h4);
    settle();
    rreg(fml_pkg::OFS_HISTORY, 32'h1C2, "armed restart");
  endtask

  task automatic t_power();
    hw <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    wreg(fml_pkg::OFS_CONFIG, 32'h1);
    wreg(fml_pkg::OFS_COMMAND, 32'h1);
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h1, "lock after reset");
    rreg(fml_pkg::OFS_HISTORY, 32'h1, "power history");
    hw <= 1'b0;
    settle();
    u_fml_console_model.send_line(fml_pkg::CH_MENU);
    u_fml_console_model.send_line(fml_pkg::CH_UNLOCK);
    rreg(fml_pkg::OFS_ACTIVE, 32'h0, "power clean");
    perm(3'h7);
    u_fml_console_model.send_line(fml_pkg::CH_HIST);
    u_fml_console_model.send_line(fml_pkg::CH_BOOT);
    rreg(fml_pkg::OFS_HISTORY, 32'h0, "console boot");
    // only configured is set: loop, relay, precharge and inlet causes must stay quiet
    loop_ok <= 1'b0;
    leak <= 4'hF;
    mot <= 4'h8;
    settle();
    rreg(fml_pkg::OFS_ACTIVE, 32'h0, "gated faults");
    perm(3'h7);
    loop_ok <= 1'b1;
    leak <= 4'h0;
    mot <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    compares = 0;
    rst = 1'b1;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    be = 4'hF;
    hw = 1'b0;
    loop_ok = 1'b1;
    cal_bad = 1'b0;
    mot = 4'h0;
    leak = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_self();
    t_sticky();
    t_irq();
    t_console();
    t_power();
    give_verdict();
  end
endmodule
